// ==== rtl/cmw_consts.vh ====
// Constants for the compare-match waveform timer block
`ifndef CMW_CONSTS_VH
`define CMW_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CMW_A_CTRL0 8'h00
`define CMW_A_COUNT0 8'h04
`define CMW_A_CMP0 8'h08
`define CMW_A_CTRL1 8'h0C
`define CMW_A_COUNT1 8'h10
`define CMW_A_CMPA1 8'h14
`define CMW_A_CMPB1 8'h18
`define CMW_A_CAPT1 8'h1C
`define CMW_A_PORT 8'h20
`define CMW_A_FLAGS 8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMW_F_MODE0 0
`define CMW_F_COM0 2
`define CMW_F_PSC0 4
`define CMW_F_FORCE0 7
`define CMW_F_MODE1 0
`define CMW_F_COM1 3
`define CMW_F_PSC1 7
`define CMW_F_FORCE1 10
`define CMW_F_WAVE 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CMW_RST_CTRL0 7'h00
`define CMW_RST_CTRL1 10'h000
`define CMW_RST_PORT 6'h00
`define CMW_RST_FLAGS 6'h00

// ----------------------------------------------------------------
// Modes, prescaler codes and counter limits
// ----------------------------------------------------------------
`define CMW_M0_NORMAL 2'h0
`define CMW_M0_PC 2'h1
`define CMW_M0_CTC 2'h2
`define CMW_M0_FAST 2'h3
`define CMW_M1_NORMAL 3'h0
`define CMW_M1_CTC 3'h1
`define CMW_M1_F8 3'h2
`define CMW_M1_F9 3'h3
`define CMW_M1_F10 3'h4
`define CMW_M1_FCAP 3'h5
`define CMW_M1_FA 3'h6
`define CMW_PS_DIV1 3'h1
`define CMW_PS_DIV8 3'h2
`define CMW_PS_DIV64 3'h3
`define CMW_PS_DIV256 3'h4
`define CMW_PS_DIV1024 3'h5
`define CMW_MAX8 8'hFF
`define CMW_BOTTOM8 8'h00
`define CMW_MAX16 16'hFFFF
`define CMW_TOP_F8 16'h00FF
`define CMW_TOP_F9 16'h01FF
`define CMW_TOP_F10 16'h03FF

`endif

// ==== rtl/cmw_timer_wave.v ====
// Compare-match waveform generator for an 8-bit and a 16-bit timer
`timescale 1ns/100ps
`include "cmw_consts.vh"

module cmw_timer_wave (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Capture input pin
  input wire capture_in,
  // Waveform pins
  output reg pin_out_t0,
  output reg pin_oe_t0,
  output reg pin_out_a_t1,
  output reg pin_oe_a_t1,
  output reg pin_out_b_t1,
  output reg pin_oe_b_t1
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [6:0] ctrl0;
  reg [9:0] ctrl1, psc;
  reg [5:0] port_ctl, flags;
  reg [7:0] count_t0, cmp_buf_t0, compare_value_t0, wr_addr;
  reg dir_down_t0, waveform_out_t0, wr_pend;
  reg cap_s1, cap_s2, cap_s3;
  reg [15:0] count_t1, capture_value_t1, top1, mask1;
  reg [31:0] rd_data;

  wire [1:0] waveform_out_t1, match_t1;
  wire [31:0] cmp_act_t1, cmp_buf_t1;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  function psc_tick(input [2:0] sel, input [9:0] cnt);
    case (sel)
      `CMW_PS_DIV1: psc_tick = 1'b1;
      `CMW_PS_DIV8: psc_tick = &cnt[2:0];
      `CMW_PS_DIV64: psc_tick = &cnt[5:0];
      `CMW_PS_DIV256: psc_tick = &cnt[7:0];
      `CMW_PS_DIV1024: psc_tick = &cnt[9:0];
      default: psc_tick = 1'b0;
    endcase
  endfunction
  // Non-PWM compare action: toggle, clear, set or hold
  function nonpwm_act(input [1:0] com, input cur);
    case (com)
      2'h1: nonpwm_act = ~cur;
      2'h2: nonpwm_act = 1'b0;
      2'h3: nonpwm_act = 1'b1;
      default: nonpwm_act = cur;
    endcase
  endfunction
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc <= 10'h000;
    end else begin
      psc <= psc + 10'h001;
    end
  end

  wire tick0 = psc_tick(ctrl0[`CMW_F_PSC0+2:`CMW_F_PSC0], psc);
  wire tick1 = psc_tick(ctrl1[`CMW_F_PSC1+2:`CMW_F_PSC1], psc);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  wire acc = hsel & htrans[1] & hready;
  wire wr_ctrl0 = wr_pend & (wr_addr == `CMW_A_CTRL0);
  wire wr_count0 = wr_pend & (wr_addr == `CMW_A_COUNT0);
  wire wr_cmp0 = wr_pend & (wr_addr == `CMW_A_CMP0);
  wire wr_ctrl1 = wr_pend & (wr_addr == `CMW_A_CTRL1);
  wire wr_count1 = wr_pend & (wr_addr == `CMW_A_COUNT1);
  wire wr_capt = wr_pend & (wr_addr == `CMW_A_CAPT1);
  wire wr_port = wr_pend & (wr_addr == `CMW_A_PORT);
  wire wr_flags = wr_pend & (wr_addr == `CMW_A_FLAGS);
  wire force0 = wr_ctrl0 & hwdata[`CMW_F_FORCE0];

  always @* begin
    case (haddr[7:0])
      `CMW_A_CTRL0: rd_data = {25'h0, ctrl0};
      `CMW_A_COUNT0: rd_data = {24'h0, count_t0};
      `CMW_A_CMP0: rd_data = {24'h0, cmp_buf_t0};
      `CMW_A_CTRL1: rd_data = {22'h0, ctrl1};
      `CMW_A_COUNT1: rd_data = {16'h0, count_t1};
      `CMW_A_CMPA1: rd_data = {16'h0, cmp_buf_t1[15:0]};
      `CMW_A_CMPB1: rd_data = {16'h0, cmp_buf_t1[31:16]};
      `CMW_A_CAPT1: rd_data = {16'h0, capture_value_t1};
      `CMW_A_PORT: rd_data = {26'h0, port_ctl};
      `CMW_A_FLAGS: rd_data = {21'h0, waveform_out_t1, waveform_out_t0, 2'h0, flags};
      default: rd_data = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= acc & hwrite;
      wr_addr <= haddr[7:0];
      hrdata <= (acc & ~hwrite) ? rd_data : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0 <= `CMW_RST_CTRL0;
      ctrl1 <= `CMW_RST_CTRL1;
      port_ctl <= `CMW_RST_PORT;
    end else begin
      if (wr_ctrl0) ctrl0 <= hwdata[6:0];
      if (wr_ctrl1) ctrl1 <= hwdata[9:0];
      if (wr_port) port_ctl <= hwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Timer0: counter, compare buffer, waveform
  // ----------------------------------------------------------------
  wire [1:0] mode0 = ctrl0[`CMW_F_MODE0+1:`CMW_F_MODE0];
  wire [1:0] com0 = ctrl0[`CMW_F_COM0+1:`CMW_F_COM0];
  wire pwm0 = (mode0 == `CMW_M0_FAST) | (mode0 == `CMW_M0_PC);
  wire at_max0 = count_t0 == `CMW_MAX8;
  wire at_bot0 = count_t0 == `CMW_BOTTOM8;
  wire match0 = count_t0 == compare_value_t0;
  wire up_phase0 = ~dir_down_t0 | at_bot0;
  wire ovf0 = tick0 & ((mode0 == `CMW_M0_PC) ? (dir_down_t0 & at_bot0) : at_max0);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_t0 <= 8'h00;
      dir_down_t0 <= 1'b0;
    end else if (wr_count0) begin
      count_t0 <= hwdata[7:0];
    end else if (tick0) begin
      if (mode0 == `CMW_M0_PC) begin
        if (!dir_down_t0 && at_max0) begin
          dir_down_t0 <= 1'b1;
          count_t0 <= count_t0 - 8'h01;
        end else if (dir_down_t0 && at_bot0) begin
          dir_down_t0 <= 1'b0;
          count_t0 <= count_t0 + 8'h01;
        end else if (dir_down_t0) begin
          count_t0 <= count_t0 - 8'h01;
        end else begin
          count_t0 <= count_t0 + 8'h01;
        end
      end else if (mode0 == `CMW_M0_CTC && match0) begin
        dir_down_t0 <= 1'b0;
        count_t0 <= 8'h00;
      end else begin
        dir_down_t0 <= 1'b0;
        count_t0 <= count_t0 + 8'h01;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_buf_t0 <= 8'h00;
      compare_value_t0 <= 8'h00;
    end else if (wr_cmp0) begin
      cmp_buf_t0 <= hwdata[7:0];
      if (!pwm0) compare_value_t0 <= hwdata[7:0];
    end else if (tick0 && pwm0 && at_max0 && !dir_down_t0) begin
      compare_value_t0 <= cmp_buf_t0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      waveform_out_t0 <= 1'b0;
    end else if (force0 && !pwm0) begin
      waveform_out_t0 <= nonpwm_act(hwdata[`CMW_F_COM0+1:`CMW_F_COM0], waveform_out_t0);
    end else if (tick0) begin
      case (mode0)
        `CMW_M0_FAST: begin
          if (com0[1]) begin
            if (at_max0) begin
              waveform_out_t0 <= ~com0[0];
            end else if (match0) begin
              waveform_out_t0 <= com0[0];
            end
          end
        end
        `CMW_M0_PC: begin
          if (com0[1]) begin
            if (!dir_down_t0 && at_max0) begin
              // At MAX take the up-count level unless the new compare is MAX
              waveform_out_t0 <= (cmp_buf_t0 == `CMW_MAX8) ? ~com0[0] : com0[0];
            end else if (match0) begin
              waveform_out_t0 <= up_phase0 ? com0[0] : ~com0[0];
            end
          end
        end
        default: begin
          if (match0) begin
            waveform_out_t0 <= nonpwm_act(com0, waveform_out_t0);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timer1: TOP select, counter, input capture
  // ----------------------------------------------------------------
  wire [2:0] mode1 = ctrl1[`CMW_F_MODE1+2:`CMW_F_MODE1];
  wire pwm1 = (mode1 >= `CMW_M1_F8) & (mode1 <= `CMW_M1_FA);
  wire at_top1 = count_t1 == top1;
  wire ovf1 = tick1 & (pwm1 ? at_top1 : (count_t1 == `CMW_MAX16));
  wire cap_edge = cap_s2 & ~cap_s3;

  always @* begin
    case (mode1)
      `CMW_M1_CTC: top1 = cmp_act_t1[15:0];
      `CMW_M1_FA: top1 = cmp_act_t1[15:0];
      `CMW_M1_F8: top1 = `CMW_TOP_F8;
      `CMW_M1_F9: top1 = `CMW_TOP_F9;
      `CMW_M1_F10: top1 = `CMW_TOP_F10;
      `CMW_M1_FCAP: top1 = capture_value_t1;
      default: top1 = `CMW_MAX16;
    endcase
    case (mode1)
      `CMW_M1_F8: mask1 = `CMW_TOP_F8;
      `CMW_M1_F9: mask1 = `CMW_TOP_F9;
      `CMW_M1_F10: mask1 = `CMW_TOP_F10;
      default: mask1 = `CMW_MAX16;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_t1 <= 16'h0000;
    end else if (wr_count1) begin
      count_t1 <= hwdata[15:0];
    end else if (tick1) begin
      // Equality only: a TOP written below the count runs on through MAX
      count_t1 <= at_top1 ? 16'h0000 : count_t1 + 16'h0001;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_s3 <= 1'b0;
      capture_value_t1 <= 16'h0000;
    end else begin
      cap_s1 <= capture_in;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
      if (wr_capt) begin
        capture_value_t1 <= hwdata[15:0];
      end else if (cap_edge && mode1 != `CMW_M1_FCAP) begin
        capture_value_t1 <= count_t1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer1 compare channels A and B
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg [15:0] cmp_buf;
      reg [15:0] compare_value_t1;
      reg wave;
      wire [1:0] com = ctrl1[`CMW_F_COM1+2*ch+1:`CMW_F_COM1+2*ch];
      wire wr_c = wr_pend & (wr_addr == (ch == 0 ? `CMW_A_CMPA1 : `CMW_A_CMPB1));
      wire force_c = wr_ctrl1 & hwdata[`CMW_F_FORCE1+ch];
      wire hit = (count_t1 == compare_value_t1) & (compare_value_t1 <= top1);

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_buf <= 16'h0000;
          compare_value_t1 <= 16'h0000;
        end else if (wr_c) begin
          cmp_buf <= hwdata[15:0] & mask1;
          if (!pwm1) compare_value_t1 <= hwdata[15:0] & mask1;
        end else if (tick1 && pwm1 && at_top1) begin
          compare_value_t1 <= cmp_buf;
        end
      end

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          wave <= 1'b0;
        end else if (force_c && !pwm1) begin
          wave <= nonpwm_act(hwdata[`CMW_F_COM1+2*ch+1:`CMW_F_COM1+2*ch], wave);
        end else if (tick1) begin
          if (pwm1) begin
            if (com[1] && at_top1) begin
              wave <= ~com[0];
            end else if (com[1] && hit) begin
              wave <= com[0];
            end
          end else if (hit) begin
            wave <= nonpwm_act(com, wave);
          end
        end
      end

      assign waveform_out_t1[ch] = wave;
      assign match_t1[ch] = tick1 & hit;
      assign cmp_act_t1[16*ch+15:16*ch] = compare_value_t1;
      assign cmp_buf_t1[16*ch+15:16*ch] = cmp_buf;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags: hardware set wins over write-one-to-clear
  // ----------------------------------------------------------------
  wire [5:0] flag_set;
  assign flag_set[0] = ovf0;
  assign flag_set[1] = tick0 & match0;
  assign flag_set[2] = ovf1;
  assign flag_set[3] = match_t1[0] | (tick1 & at_top1 & (mode1 == `CMW_M1_FA));
  assign flag_set[4] = match_t1[1];
  assign flag_set[5] = (cap_edge & (mode1 != `CMW_M1_FCAP))
                     | (tick1 & at_top1 & (mode1 == `CMW_M1_FCAP));

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= `CMW_RST_FLAGS;
    end else begin
      flags <= (flags & ~(wr_flags ? hwdata[5:0] : 6'h00)) | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // Pin override
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_t0 <= 1'b0;
      pin_oe_t0 <= 1'b0;
      pin_out_a_t1 <= 1'b0;
      pin_oe_a_t1 <= 1'b0;
      pin_out_b_t1 <= 1'b0;
      pin_oe_b_t1 <= 1'b0;
    end else begin
      pin_out_t0 <= (|com0) ? waveform_out_t0 : port_ctl[0];
      pin_oe_t0 <= port_ctl[1];
      pin_out_a_t1 <= (|ctrl1[4:3]) ? waveform_out_t1[0] : port_ctl[2];
      pin_oe_a_t1 <= port_ctl[3];
      pin_out_b_t1 <= (|ctrl1[6:5]) ? waveform_out_t1[1] : port_ctl[4];
      pin_oe_b_t1 <= port_ctl[5];
    end
  end

endmodule

// ==== verif/cmw_timer_wave_assertions.sv ====
// Concurrent checks on the ports of the waveform block
`timescale 1ns/100ps
`include "cmw_consts.vh"
module cmw_timer_wave_chk (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Waveform pins
  input wire pin_out_t0,
  input wire pin_oe_t0,
  input wire pin_out_a_t1,
  input wire pin_oe_a_t1,
  input wire pin_out_b_t1,
  input wire pin_oe_b_t1
);
  default clocking cmw_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Shadow of written control state
  // ----------------------------------------------------------------
  reg wr_d, rd_d;
  reg [7:0] a_d;
  reg [5:0] sh_port;
  reg [6:0] sh_c0;
  reg [1:0] sh_coma, sh_comb, nr;
  reg [8:0] gap;
  wire take = hsel & htrans[1] & hready;
  wire fast_on = sh_c0 == {`CMW_PS_DIV1, 2'h2, `CMW_M0_FAST};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_d <= 1'h0;
      rd_d <= 1'h0;
      a_d <= 8'h00;
      sh_port <= 6'h00;
      sh_c0 <= 7'h00;
      {sh_comb, sh_coma} <= 4'h0;
      gap <= 9'h000;
      nr <= 2'h0;
    end else begin
      wr_d <= take & hwrite;
      rd_d <= take & !hwrite;
      a_d <= haddr[7:0];
      if (wr_d && a_d == `CMW_A_PORT) sh_port <= hwdata[5:0];
      if (wr_d && a_d == `CMW_A_CTRL0) sh_c0 <= hwdata[6:0];
      if (wr_d && a_d == `CMW_A_CTRL1) {sh_comb, sh_coma} <= hwdata[6:3];
      // First two rises after any write may still show the old setting
      if (wr_d) begin
        gap <= 9'h000;
        nr <= 2'h0;
      end else if ($rose(pin_out_t0)) begin
        gap <= 9'h001;
        if (nr != 2'h2) nr <= nr + 2'h1;
      end else if (gap != 9'h000 && gap != 9'h1FF) gap <= gap + 9'h001;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_high_a: assert property (hreadyout) else $error("hreadyout dropped");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  rdata_idle_a: assert property (!rd_d |-> hrdata == 32'h0)
    else $error("hrdata not zero outside a read");
  dir_follow_a: assert property (
    {pin_oe_b_t1, pin_oe_a_t1, pin_oe_t0} == $past({sh_port[5], sh_port[3], sh_port[1]}))
    else $error("pin enable differs from direction bit");
  port_t0_a: assert property ($past(sh_c0[3:2]) == 2'h0 |-> pin_out_t0 == $past(sh_port[0]))
    else $error("t0 pin not port value");
  port_a_a: assert property ($past(sh_coma) == 2'h0 |-> pin_out_a_t1 == $past(sh_port[2]))
    else $error("A pin not port value");
  port_b_a: assert property ($past(sh_comb) == 2'h0 |-> pin_out_b_t1 == $past(sh_port[4]))
    else $error("B pin not port value");
  reset_pins_a: assert property ($rose(hresetn) |->
    {pin_out_t0, pin_oe_t0, pin_out_a_t1, pin_oe_a_t1, pin_out_b_t1, pin_oe_b_t1} == 6'h00)
    else $error("pins not low after reset");
  fast_period_a: assert property (fast_on && nr == 2'h2 && $rose(pin_out_t0) |-> gap == 9'h100)
    else $error("fast period not 256");
  cover property (fast_on && nr == 2'h2 && $rose(pin_out_t0));
  cover property (wr_d && a_d == `CMW_A_PORT);
  cover property (rd_d && hrdata != 32'h0);
endmodule
bind cmw_timer_wave cmw_timer_wave_chk u_cmw_timer_wave_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pin_out_t0(pin_out_t0), .pin_oe_t0(pin_oe_t0), .pin_out_a_t1(pin_out_a_t1),
  .pin_oe_a_t1(pin_oe_a_t1), .pin_out_b_t1(pin_out_b_t1), .pin_oe_b_t1(pin_oe_b_t1));

// ==== verif/cmw_pin_model.sv ====
// Pin-side model: pulled-up line with waveform timing monitor
`timescale 1ns/100ps
module cmw_pin_model #(
  parameter PULL = 1'h1
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Pin from the block
  input wire pin_out,
  input wire pin_oe,
  // Observed line and timing
  output wire level,
  output reg [15:0] period,
  output reg [15:0] high_len,
  output reg [15:0] edges
);
  reg last;
  reg [15:0] since_rise, since_edge;
  // ----------------------------------------------------------------
  // Undriven line floats to the pull-up level
  // ----------------------------------------------------------------
  assign level = pin_oe ? pin_out : PULL;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last <= PULL;
      period <= 16'h0000;
      high_len <= 16'h0000;
      edges <= 16'h0000;
      since_rise <= 16'h0000;
      since_edge <= 16'h0000;
    end else begin
      last <= level;
      since_rise <= since_rise + 16'h0001;
      since_edge <= since_edge + 16'h0001;
      if (level != last) edges <= edges + 16'h0001;
      if (level != last) since_edge <= 16'h0001;
      if (level && !last) period <= since_rise;
      if (level && !last) since_rise <= 16'h0001;
      if (!level && last) high_len <= since_edge;
    end
  end
endmodule

// ==== verif/compare_match_waveform_output_bench.sv ====
// Self-checking bench for the compare-match waveform block
`timescale 1ns/100ps
`include "cmw_consts.vh"
module compare_match_waveform_output_bench;
  // ----------------------------------------------------------------
  // Clock, reset and design
  // ----------------------------------------------------------------
  reg hclk, hresetn, hsel, hwrite, capture_in, w;
  reg [31:0] haddr, hwdata, q;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [5:0] v;
  reg [7:0] a, c;
  reg [9:0] coms;
  wire [31:0] hrdata;
  wire hreadyout, hresp;
  wire [2:0] pout, poe, lvl;
  wire [15:0] per [0:2];
  wire [15:0] hi [0:2];
  wire [15:0] ed [0:2];
  integer i, n_fail, n_checks;
  int unsigned r;
  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end
  cmw_timer_wave u_cmw_timer_wave (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .capture_in(capture_in), .pin_out_t0(pout[0]), .pin_oe_t0(poe[0]),
    .pin_out_a_t1(pout[1]), .pin_oe_a_t1(poe[1]), .pin_out_b_t1(pout[2]),
    .pin_oe_b_t1(poe[2]));
  genvar g;
  for (g = 0; g < 3; g = g + 1) begin : g_pin
    cmw_pin_model u_cmw_pin_model (.hclk(hclk), .hresetn(hresetn), .pin_out(pout[g]),
      .pin_oe(poe[g]), .level(lvl[g]), .period(per[g]), .high_len(hi[g]), .edges(ed[g]));
  end
  // ----------------------------------------------------------------
  // Bus, compare and expectation helpers
  // ----------------------------------------------------------------
  task bus(input reg wn, input reg [7:0] ad, input reg [31:0] d);
    begin
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wn;
      haddr <= {24'h000000, ad};
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  task wr(input reg [7:0] ad, input reg [31:0] d);
    bus(1'h1, ad, d);
  endtask
  task rd(input reg [7:0] ad);
    bus(1'h0, ad, 32'h0);
  endtask
  task chk(input reg [31:0] got, input reg [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  function [2:0] exp_lvl(input reg [5:0] p);
    exp_lvl = {p[5] ? p[4] : 1'h1, p[3] ? p[2] : 1'h1, p[1] ? p[0] : 1'h1};
  endfunction
  function wave_after(input reg [1:0] cm, input reg cur);
    wave_after = cm == 2'h1 ? !cur : cm == 2'h2 ? 1'h0 : cm == 2'h3 ? 1'h1 : cur;
  endfunction
  function [15:0] exp_per(input reg pc);
    exp_per = pc ? 16'h01FE : 16'h0100;
  endfunction
  function [15:0] exp_hi(input reg pc, input reg inv, input reg [7:0] cv);
    if (pc) exp_hi = inv ? 16'h01FE - {7'h00, cv, 1'h0} : {7'h00, cv, 1'h0};
    else exp_hi = inv ? 16'h00FF - {8'h00, cv} : {8'h00, cv} + 16'h0001;
  endfunction
  task run_pwm(input reg pc, input reg inv, input reg [7:0] cv);
    reg [15:0] e0, hx;
    begin
      hx = exp_hi(pc, inv, cv);
      wr(`CMW_A_CMP0, {24'h000000, cv});
      wr(`CMW_A_CTRL0, {25'h0000000, `CMW_PS_DIV1, inv ? 2'h3 : 2'h2,
        pc ? `CMW_M0_PC : `CMW_M0_FAST});
      repeat (1100) @(posedge hclk);
      e0 = ed[0];
      repeat (520) @(posedge hclk);
      if (hx == 16'h0000 || hx == exp_per(pc)) begin
        chk({16'h0000, ed[0] - e0}, 32'h0);
        chk({31'h0, lvl[0]}, {31'h0, hx != 16'h0000});
      end else begin
        chk({16'h0000, per[0]}, {16'h0000, exp_per(pc)});
        chk({16'h0000, hi[0]}, {16'h0000, hx});
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #2000000;
    n_fail = n_fail + 1;
    give_verdict;
  end
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    hwrite = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    capture_in = 1'h0;
    n_fail = 0;
    n_checks = 0;
    r = $urandom(32'hB52C51E7);
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    wr(8'h28, 32'hFFFFFFFF);
    for (a = 8'h00; a <= 8'h28; a = a + 8'h04) begin
      rd(a);
      chk(q, 32'h0);
    end
    chk({29'h0, lvl}, 32'h7);
    $display("test reset values done");
    for (i = 0; i < 8; i = i + 1) begin
      v = i == 0 ? 6'h3F : 6'($urandom);
      wr(`CMW_A_PORT, {26'h0, v});
      rd(`CMW_A_PORT);
      chk(q, {26'h0, v});
      chk({29'h0, lvl}, {29'h0, exp_lvl(v)});
    end
    $display("test port pass done");
    wr(`CMW_A_PORT, 32'h0);
    coms = 10'b01_00_01_10_11;
    w = 1'h0;
    for (i = 0; i < 5; i = i + 1) begin
      wr(`CMW_A_CTRL1, {21'h000000, 1'h1, 5'h00, coms[2 * i +: 2], 3'h0});
      w = wave_after(coms[2 * i +: 2], w);
      rd(`CMW_A_FLAGS);
      chk((q >> 9) & 32'h1, {31'h0, w});
      chk({31'h0, lvl[1]}, 32'h1);
    end
    wr(`CMW_A_PORT, 32'h0000000C);
    repeat (3) @(posedge hclk);
    chk({31'h0, lvl[1]}, {31'h0, w});
    wr(`CMW_A_CTRL1, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, lvl[1]}, 32'h1);
    $display("test force strobe done");
    wr(`CMW_A_PORT, 32'h00000002);
    for (i = 0; i < 16; i = i + 1) begin
      c = 8'h01 + 8'($urandom % 254);
      if (i[3:2] == 2'h0) c = 8'h00;
      if (i[3:2] == 2'h1) c = 8'hFF;
      run_pwm(i[0], i[1], c);
    end
    $display("test timer0 pwm done");
    wr(`CMW_A_CTRL1, {22'h000000, `CMW_PS_DIV1, 4'h0, `CMW_M1_F8});
    r = $urandom;
    wr(`CMW_A_CMPA1, r);
    rd(`CMW_A_CMPA1);
    chk(q, r & 32'h000000FF);
    wr(`CMW_A_CTRL1, 32'h0);
    wr(`CMW_A_CMPA1, 32'h00000040);
    wr(`CMW_A_CMPB1, 32'h00000050);
    wr(`CMW_A_CTRL1, {22'h000000, `CMW_PS_DIV1, 4'h0, `CMW_M1_FA});
    repeat (300) @(posedge hclk);
    wr(`CMW_A_FLAGS, 32'h0000003F);
    repeat (200) @(posedge hclk);
    rd(`CMW_A_FLAGS);
    chk((q >> 2) & 32'hF, 32'h3);
    $display("test timer1 top done");
    wr(`CMW_A_CTRL1, {22'h000000, `CMW_PS_DIV1, 4'h2, `CMW_M1_NORMAL});
    wr(`CMW_A_FLAGS, 32'h0000003F);
    repeat (1 + $urandom % 20) @(posedge hclk);
    rd(`CMW_A_FLAGS);
    chk((q >> 5) & 32'h1, 32'h0);
    capture_in <= 1'h1;
    repeat (4) @(posedge hclk);
    capture_in <= 1'h0;
    repeat (6) @(posedge hclk);
    rd(`CMW_A_FLAGS);
    chk((q >> 5) & 32'h1, 32'h1);
    $display("test capture done");
    give_verdict;
  end
endmodule
